// [tb/inst_status_checker.sv]
// read port and state checks for the status register bank
// assumes binding to inst_status_regs on one clock
`timescale 1ns/1ps
`default_nettype none
module inst_status_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // read port
  input wire logic rd_en,
  input wire logic rd_fieldbus,
  input wire logic [7:0] rd_addr,
  input wire logic rd_valid,
  input wire logic [15:0] rd_data,
  // condition
  input wire logic special_prog,
  input wire logic cmd_done,
  input wire logic [7:0] cmd_exception,
  input wire logic startup_done,
  input wire logic startup_err,
  input wire logic startup_fatal,
  input wire logic prog_start,
  input wire logic remote_on,
  input wire logic [7:0] inst_state
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire logic sw_mb = rd_en && !rd_fieldbus && rd_addr == 8'h07;
  a_read_answer: assert property (rd_en |=> rd_valid)
    else $error("read not answered");
  a_valid_pulse: assert property (!rd_en |=> !rd_valid)
    else $error("answer without request");
  a_special_zero: assert property (
    rd_en && rd_addr[7:1] == 7'h00 && !special_prog |=> rd_data == 16'h0000)
    else $error("special version not zero");
  a_cmd_clean: assert property (
    cmd_done && !(cmd_exception inside {8'h03, 8'h07}) ##1 !cmd_done
    ##1 rd_en && rd_addr == 8'h04 && !cmd_done |=> rd_data == 16'h0000)
    else $error("command error not cleared");
  a_wait_entry: assert property (
    inst_state == 8'h00 && startup_done && !startup_err && !startup_fatal |=> inst_state == 8'h01)
    else $error("no wait state");
  a_fatal_entry: assert property (inst_state == 8'h00 && startup_fatal |=> inst_state == 8'h05)
    else $error("no fatal state");
  a_fatal_stays: assert property (inst_state == 8'h05 |=> $stable(inst_state))
    else $error("fatal state left");
  a_state_codes: assert property (inst_state inside {8'h00, 8'h01, 8'h03, 8'h04, 8'h05})
    else $error("bad state code");
  a_spare_bits: assert property (rd_en && rd_addr == 8'h07 |=> rd_data[15:2] == 14'h0000)
    else $error("spare status bits set");
  // remote level must be steady one edge before the read
  a_remote_bit: assert property (
    rd_en && rd_addr == 8'h07 && $past(resetn) && $past(remote_on) == remote_on
    |=> rd_data[0] == $past(remote_on))
    else $error("remote bit wrong");
  a_first_clear: assert property (
    sw_mb && !prog_start ##1 !prog_start ##1 sw_mb |=> !rd_data[1])
    else $error("reset bit not cleared");
endmodule : inst_status_checker
bind inst_status_regs inst_status_checker u_inst_status_checker (.mclk, .resetn, .rd_en, .rd_fieldbus,
  .rd_addr, .rd_valid, .rd_data, .special_prog, .cmd_done, .cmd_exception, .startup_done,
  .startup_err, .startup_fatal, .prog_start, .remote_on, .inst_state);
`default_nettype wire

// [tb/inst_status_regs_tb_top.sv]
// self-checking bench for the status register bank
// assumes remote_master drives reads; event pulses come from ev
`timescale 1ns/1ps
`default_nettype none
module inst_status_regs_tb_top;
  logic mclk, resetn, special_prog, param_err, remote_on, rd_en, rd_fieldbus, rd_valid;
  // ev: done, err, fatal, start, prog start, fieldbus clear, cmd done
  logic [6:0] ev;
  logic [7:0] rd_addr, cmd_exception, cmd_detail, inst_error_code, blk_fault_evt, blk_clear, inst_state, a;
  logic [15:0] special_major, special_minor, rd_data;
  logic [23:0] blk_fault_chan;
  logic [63:0] blk_fault_code, blk_out_used;
  logic [31:0] blk_in_fault;
  logic [127:0] blk_sum, blk_diff;
  logic [1023:0] blk_out;
  int n_fail = 0;
  int n_compared = 0;
  int b;
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  remote_master u_remote_master (.mclk, .rd_en, .rd_fieldbus, .rd_addr);
  inst_status_regs u_inst_status_regs (.mclk, .resetn, .rd_en, .rd_fieldbus, .rd_addr, .rd_valid,
    .rd_data, .special_prog, .special_major, .special_minor, .cmd_done(ev[6]), .cmd_exception,
    .cmd_detail, .fieldbus_reset_cmd(ev[5]), .startup_done(ev[0]), .startup_err(ev[1]),
    .startup_fatal(ev[2]), .start_cmd(ev[3]), .param_err, .inst_error_code, .remote_on,
    .prog_start(ev[4]), .blk_fault_evt, .blk_fault_chan, .blk_fault_code, .blk_in_fault, .blk_clear,
    .blk_sum, .blk_diff, .blk_out, .blk_out_used, .inst_state);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic rd(input logic [7:0] ad, input logic [15:0] e, input logic fb = 1'b0);
    u_remote_master.rd(fb, ad, e);
  endtask : rd
  task automatic rst();
    // let an answer still in flight land before reset wipes it
    if (resetn === 1'b1)
      @(posedge mclk);
    resetn <= 1'b0;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
  endtask : rst
  task automatic pulse(input logic [6:0] m);
    @(posedge mclk);
    ev <= m;
    @(posedge mclk);
    ev <= 7'h00;
  endtask : pulse
  task automatic fault(input logic cl, input logic [2:0] c, input logic [7:0] k);
    @(posedge mclk);
    blk_clear[b] <= cl;
    blk_fault_evt[b] <= ~cl;
    blk_fault_chan[3*b+:3] <= c;
    blk_fault_code[8*b+:8] <= k;
    @(posedge mclk);
    {blk_clear[b], blk_fault_evt[b]} <= 2'b00;
  endtask : fault
  task automatic end_of_test();
    if (u_remote_master.exp_q.size() != 0)
      n_fail++;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk)
  begin
    logic [15:0] e;
    if (rd_valid === 1'b1)
    begin
      e = u_remote_master.exp_q.pop_front();
      n_compared++;
      if (rd_data !== e)
      begin
        n_fail++;
        $display("mismatch t=%0t got %h exp %h", $time, rd_data, e);
      end
    end
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    end_of_test();
  end
  initial
  begin
    logic [15:0] v;
    {resetn, ev, special_prog, param_err, remote_on, cmd_exception, cmd_detail, inst_error_code} = '0;
    {blk_fault_evt, blk_clear, special_major, special_minor, blk_fault_chan, blk_fault_code} = '0;
    {blk_out_used, blk_in_fault, blk_sum, blk_diff} = '0;
    void'($urandom(32'h6531a2e1));
    for (int i = 0; i < 32; i++)
      blk_out[32*i+:32] = $urandom;
    rst();
    rd(8'h07, 16'h0002, 1'b1);
    rd(8'h07, 16'h0002, 1'b1);
    rd(8'h07, 16'h0002);
    rd(8'h07, 16'h0000);
    rd(8'h05, 16'h0000);
    rd(8'h9f, 16'h0000);
    remote_on <= 1'b1;
    rd(8'h07, 16'h0001);
    pulse(7'h10);
    rd(8'h07, 16'h0003, 1'b1);
    pulse(7'h20);
    rd(8'h07, 16'h0001, 1'b1);
    pulse(7'h10);
    rd(8'h07, 16'h0003);
    rd(8'h07, 16'h0001);
    v = 16'($urandom_range(65000, 256));
    special_major <= v;
    special_minor <= ~v;
    rd(8'h00, 16'h0000);
    rd(8'h01, 16'h0000);
    special_prog <= 1'b1;
    rd(8'h00, v);
    rd(8'h01, ~v);
    rd(8'h02, inst_status_pkg::SERIAL_DEFAULT[31:16]);
    rd(8'h03, inst_status_pkg::SERIAL_DEFAULT[15:0]);
    // exceptions 03, 07, then two that carry no detail
    for (int i = 0; i < 4; i++)
    begin
      v = (i == 0) ? 16'h00ff : 16'($urandom_range(254, 1));
      cmd_exception <= (i == 0) ? 8'h03 : (i == 1) ? 8'h07 : 8'(i - 1);
      cmd_detail <= v[7:0];
      pulse(7'h40);
      rd(8'h04, (i < 2) ? v : 16'h0000);
    end
    v = 16'($urandom_range(255, 1));
    inst_error_code <= v[7:0];
    rd(8'h06, v);
    b = $urandom_range(7);
    a = 8'(8'h10 + 16 * b);
    blk_in_fault[4*b+:4] <= 4'h5;
    rd(a + 8'h01, 16'h0005);
    blk_in_fault[4*b+:4] <= 4'ha;
    rd(a + 8'h01, 16'h000a);
    for (int c = 0; c < 5; c++)
    begin
      fault(1'b1, 3'h0, 8'h00);
      rd(a, 16'h0000);
      v = 16'($urandom_range(255, 1));
      fault(1'b0, 3'(c), v[7:0]);
      rd(a, 16'(c * 1000) + v);
    end
    fault(1'b0, 3'h1, 8'h2a);
    rd(a, 16'(4000) + v);
    fault(1'b1, 3'h0, 8'h00);
    rd(a, 16'h0000);
    v = 16'($urandom_range(65000, 256));
    blk_sum[16*b+:16] <= v;
    blk_diff[16*b+:16] <= ~v;
    rd(a + 8'h02, v);
    rd(a + 8'h03, ~v);
    for (int o = 0; o < 8; o++)
    begin
      blk_out[16*(8*b+o)+:16] <= ~v;
      blk_out_used[8*b+o] <= o[0];
      rd(a + 8'(4 + o), o[0] ? ~v : 16'h0000);
    end
    pulse(7'h01);
    rd(8'h05, 16'h0001);
    pulse(7'h08);
    rd(8'h05, 16'h0003);
    param_err <= 1'b1;
    rd(8'h05, 16'h0004);
    rst();
    pulse(7'h02);
    rd(8'h05, 16'h0004);
    rst();
    pulse(7'h05);
    pulse(7'h09);
    rd(8'h05, 16'h0005);
    repeat (4) @(posedge mclk);
    n_compared++;
    if (inst_state !== 8'h05)
    begin
      n_fail++;
      $display("mismatch t=%0t got %h exp %h", $time, inst_state, 8'h05);
    end
    end_of_test();
  end
endmodule : inst_status_regs_tb_top
`default_nettype wire

// [tb/remote_master.sv]
// remote master model: issues register reads, notes expected replies
// assumes a one-cycle answer on the read port
`timescale 1ns/1ps
`default_nettype none
module remote_master (
  // clock
  input wire logic mclk,
  // read request
  output logic rd_en,
  output logic rd_fieldbus,
  output logic [7:0] rd_addr
);
  logic [15:0] exp_q[$];
  initial
  begin
    rd_en = 1'b0;
    rd_fieldbus = 1'b0;
    rd_addr = 8'h00;
  end
  // released lines are inverted so a stale index never matches
  task automatic rd(input logic fb, input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk);
    rd_en <= 1'b1;
    rd_fieldbus <= fb;
    rd_addr <= a;
    exp_q.push_back(e);
    @(posedge mclk);
    rd_en <= 1'b0;
    rd_fieldbus <= ~fb;
    rd_addr <= ~a;
  endtask : rd
endmodule : remote_master
`default_nettype wire

// [verilog/blk_fault_capture.sv]
// one function block: first-error capture and input fault status
// assumes fault inputs are from logic on mclk
`timescale 1ns/1ps
`default_nettype none
module blk_fault_capture (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // fault sources
  input wire logic fault_evt,
  input wire logic [2:0] fault_chan,
  input wire logic [7:0] fault_code,
  input wire logic [3:0] in_fault,
  input wire logic clear,
  // register values
  output logic [15:0] err_code,
  output logic [15:0] status
);

  logic [15:0] err_reg;
  logic [15:0] err_next;
  logic [15:0] stat_reg;
  logic [15:0] stat_next;
  logic [15:0] coded;

  always_comb
  begin
    // out-of-range channel numbers fall back to a plain code
    if (fault_chan != 3'h0 && fault_chan <= inst_status_pkg::CHAN_MAX)
      coded = 16'({13'h0, fault_chan} * inst_status_pkg::CHAN_WEIGHT) + {8'h00, fault_code}; // RQ14
    else
      coded = {8'h00, fault_code}; // RQ14
    err_next = err_reg;
    if (clear)
      err_next = inst_status_pkg::ZERO_WORD;
    // a new error in the clearing cycle is kept
    if (fault_evt && (clear || err_reg == inst_status_pkg::ZERO_WORD) && coded != inst_status_pkg::ZERO_WORD)
      err_next = coded; // RQ13
    stat_next = {12'h000, in_fault}; // RQ15
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      err_reg <= 16'h0000; // RQ13
      stat_reg <= 16'h0000;
    end
    else
    begin
      err_reg <= err_next;
      stat_reg <= stat_next;
    end
  end

  assign err_code = err_reg;
  assign status = stat_reg;

endmodule : blk_fault_capture
`default_nettype wire

// [verilog/inst_state_fsm.sv]
// instrument state machine: start-up, wait, normal, error, fatal
// assumes all event inputs come from logic on mclk
`timescale 1ns/1ps
`default_nettype none
module inst_state_fsm (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // events
  input wire logic startup_done,
  input wire logic startup_err,
  input wire logic startup_fatal,
  input wire logic start_cmd,
  input wire logic param_err,
  // state
  output inst_status_pkg::inst_state_e state
);

  inst_status_pkg::inst_state_e state_reg;
  inst_status_pkg::inst_state_e state_next;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      inst_status_pkg::ST_STARTING:
      begin
        if (startup_fatal)
          state_next = inst_status_pkg::ST_FATAL; // RQ7
        else if (startup_err)
          state_next = inst_status_pkg::ST_ERROR; // RQ7
        else if (startup_done)
          state_next = inst_status_pkg::ST_WAIT_START; // RQ5
      end
      inst_status_pkg::ST_WAIT_START:
      begin
        if (start_cmd)
          state_next = param_err ? inst_status_pkg::ST_ERROR : inst_status_pkg::ST_NORMAL; // RQ6
      end
      inst_status_pkg::ST_NORMAL:
      begin
        // force value errors do not arrive here, only parameter errors
        if (param_err)
          state_next = inst_status_pkg::ST_ERROR; // RQ6
      end
      inst_status_pkg::ST_ERROR:
        state_next = inst_status_pkg::ST_ERROR;
      inst_status_pkg::ST_FATAL:
        state_next = inst_status_pkg::ST_FATAL; // RQ7
    endcase
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      state_reg <= inst_status_pkg::ST_STARTING; // RQ4
    else
      state_reg <= state_next;
  end

  assign state = state_reg;

endmodule : inst_state_fsm
`default_nettype wire

// [verilog/inst_status_pkg.sv]
// constants and types for the instrument status register bank
// assumes register indices are word addresses on the internal read port
package inst_status_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned BLOCKS = 8;
  localparam int unsigned OUTPUTS = 8;
  localparam int unsigned INPUTS = 4;

  // instrument-wide registers
  localparam logic [7:0] REG_SPECIAL_MAJOR = 8'h00;
  localparam logic [7:0] REG_SPECIAL_MINOR = 8'h01;
  localparam logic [7:0] REG_SERIAL_HI = 8'h02;
  localparam logic [7:0] REG_SERIAL_LO = 8'h03;
  localparam logic [7:0] REG_COMMAND_ERROR = 8'h04;
  localparam logic [7:0] REG_INST_STATE = 8'h05;
  localparam logic [7:0] REG_INST_ERROR = 8'h06;
  localparam logic [7:0] REG_STATUS_WORD = 8'h07;

  // function block window: base + block * stride + field
  localparam logic [7:0] BLK_BASE = 8'h10;
  localparam logic [7:0] BLK_STRIDE = 8'h10;
  localparam logic [3:0] BLK_ERROR_CODE = 4'h0;
  localparam logic [3:0] BLK_STATUS = 4'h1;
  localparam logic [3:0] BLK_SUM = 4'h2;
  localparam logic [3:0] BLK_DIFF = 4'h3;
  localparam logic [3:0] BLK_OUT_FIRST = 4'h4;
  localparam logic [3:0] BLK_OUT_LAST = 4'hb;

  // status word fields
  localparam int unsigned STAT_REMOTE_BIT = 0;
  localparam int unsigned STAT_PROG_RESET_BIT = 1;
  localparam logic STAT_PROG_RESET_RST = 1'b1;

  // command exceptions that carry a detailed code
  localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
  localparam logic [7:0] EXC_NEG_ACK = 8'h07;
  localparam logic [7:0] NO_ERROR = 8'h00;

  // channel-prefixed block error codes: chan * 1000 + code
  localparam logic [15:0] CHAN_WEIGHT = 16'h03e8;
  localparam logic [2:0] CHAN_MAX = 3'h4;

  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [31:0] SERIAL_DEFAULT = 32'h0000_0001; // arbitrary

  typedef enum logic [7:0] {
    ST_STARTING = 8'h00,
    ST_WAIT_START = 8'h01,
    ST_NORMAL = 8'h03,
    ST_ERROR = 8'h04,
    ST_FATAL = 8'h05
  } inst_state_e;

endpackage : inst_status_pkg

// [verilog/inst_status_regs.sv]
// instrument status and diagnostic register bank
//
// Contract
// [RQ1] special version reads zero for standard program
// [RQ2] exception 03/07 stores detailed command error
// [RQ3] command error 0..255, 00 means none
// [RQ4] state 00 while starting up
// [RQ5] state 01 while waiting for start
// [RQ6] state 03 normal; force errors keep it
// [RQ7] startup error gives 04; fatal 05 terminal
// [RQ8] instrument error holds overall code, 00 none
// [RQ9] status bit 0 shows remote operation
// [RQ10] status bit 1 set on program start
// [RQ11] first modbus status read clears bit 1
// [RQ12] fieldbus read keeps bit; command clears it
// [RQ13] block error holds first error, 000 none
// [RQ14] block error plain or channel-prefixed code
// [RQ15] block status bits 0-3 flag inputs A-D
// [RQ16] master trusts values only when error 00
// [RQ17] unused block outputs read zero
// [RQ18] unassigned status bits read zero, unwritable
//
// assumes one read port shared by the modbus and fieldbus front ends,
// all inputs from logic on mclk
`timescale 1ns/1ps
`default_nettype none
module inst_status_regs #(
  parameter logic [31:0] SERIAL_NUMBER = inst_status_pkg::SERIAL_DEFAULT // arbitrary
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // register read port
  input wire logic rd_en,
  input wire logic rd_fieldbus,
  input wire logic [7:0] rd_addr,
  output logic rd_valid,
  output logic [15:0] rd_data,
  // program identity
  input wire logic special_prog,
  input wire logic [15:0] special_major,
  input wire logic [15:0] special_minor,
  // command results
  input wire logic cmd_done,
  input wire logic [7:0] cmd_exception,
  input wire logic [7:0] cmd_detail,
  input wire logic fieldbus_reset_cmd,
  // instrument condition
  input wire logic startup_done,
  input wire logic startup_err,
  input wire logic startup_fatal,
  input wire logic start_cmd,
  input wire logic param_err,
  input wire logic [7:0] inst_error_code,
  input wire logic remote_on,
  input wire logic prog_start,
  // function blocks
  input wire logic [7:0] blk_fault_evt,
  input wire logic [23:0] blk_fault_chan,
  input wire logic [63:0] blk_fault_code,
  input wire logic [31:0] blk_in_fault,
  input wire logic [7:0] blk_clear,
  input wire logic [127:0] blk_sum,
  input wire logic [127:0] blk_diff,
  input wire logic [1023:0] blk_out,
  input wire logic [63:0] blk_out_used,
  // state view
  output logic [7:0] inst_state
);

  ////////////////////////////////////////////////////////////////////////
  // instrument state

  inst_status_pkg::inst_state_e state;

  inst_state_fsm u_state (
    .mclk(mclk),
    .resetn(resetn),
    .startup_done(startup_done),
    .startup_err(startup_err),
    .startup_fatal(startup_fatal),
    .start_cmd(start_cmd),
    .param_err(param_err),
    .state(state)
  );

  assign inst_state = state;

  ////////////////////////////////////////////////////////////////////////
  // function blocks

  logic [15:0] blk_err [inst_status_pkg::BLOCKS];
  logic [15:0] blk_stat [inst_status_pkg::BLOCKS];
  logic [15:0] sum_word [inst_status_pkg::BLOCKS];
  logic [15:0] diff_word [inst_status_pkg::BLOCKS];
  logic [15:0] out_word [inst_status_pkg::BLOCKS * inst_status_pkg::OUTPUTS];

  genvar gb;
  genvar go;
  generate
    for (gb = 0; gb < inst_status_pkg::BLOCKS; gb++)
    begin : g_blk
      blk_fault_capture u_cap (
        .mclk(mclk),
        .resetn(resetn),
        .fault_evt(blk_fault_evt[gb]),
        .fault_chan(blk_fault_chan[gb*3 +: 3]),
        .fault_code(blk_fault_code[gb*8 +: 8]),
        .in_fault(blk_in_fault[gb*4 +: 4]),
        .clear(blk_clear[gb]),
        .err_code(blk_err[gb]),
        .status(blk_stat[gb])
      );
      assign sum_word[gb] = blk_sum[gb*16 +: 16];
      assign diff_word[gb] = blk_diff[gb*16 +: 16];

      for (go = 0; go < inst_status_pkg::OUTPUTS; go++)
      begin : g_out
        // unused outputs are zeroed here so the read mux stays a plain index
        assign out_word[gb*8+go] = blk_out_used[gb*8+go] ?
          blk_out[(gb*8+go)*16 +: 16] : inst_status_pkg::ZERO_WORD; // RQ17
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // command error and instrument error

  logic [7:0] cmd_err_reg;
  logic [7:0] cmd_err_next;
  logic [7:0] inst_err_reg;
  logic [7:0] inst_err_next;

  always_comb
  begin
    cmd_err_next = cmd_err_reg;
    if (cmd_done)
    begin
      // 8-bit field keeps the code inside 0..255
      if (cmd_exception == inst_status_pkg::EXC_ILLEGAL_VALUE ||
          cmd_exception == inst_status_pkg::EXC_NEG_ACK)
        cmd_err_next = cmd_detail; // RQ2 RQ3
      else
        cmd_err_next = inst_status_pkg::NO_ERROR; // RQ3
    end
    inst_err_next = inst_error_code; // RQ8
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      cmd_err_reg <= 8'h00; // RQ3
      inst_err_reg <= 8'h00;
    end
    else
    begin
      cmd_err_reg <= cmd_err_next;
      inst_err_reg <= inst_err_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status word

  logic remote_reg;
  logic remote_next;
  logic prog_reset_reg;
  logic prog_reset_next;
  logic first_read_reg;
  logic first_read_next;
  logic status_rd_modbus;
  logic [15:0] status_word;

  // both front ends share one bit: a modbus read may clear it before a fieldbus master sees it
  assign status_rd_modbus = rd_en && !rd_fieldbus && rd_addr == inst_status_pkg::REG_STATUS_WORD;

  always_comb
  begin
    remote_next = remote_on; // RQ9
    prog_reset_next = prog_reset_reg;
    first_read_next = first_read_reg;
    // only the first modbus read after start clears; later ones are harmless
    if (status_rd_modbus && !first_read_reg)
    begin
      prog_reset_next = 1'b0; // RQ11
      first_read_next = 1'b1; // RQ11
    end
    if (fieldbus_reset_cmd)
      prog_reset_next = 1'b0; // RQ12
    // a program start in the clearing cycle wins
    if (prog_start)
    begin
      prog_reset_next = 1'b1; // RQ10
      first_read_next = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      remote_reg <= 1'b0;
      prog_reset_reg <= inst_status_pkg::STAT_PROG_RESET_RST; // RQ10
      first_read_reg <= 1'b0;
    end
    else
    begin
      remote_reg <= remote_next;
      prog_reset_reg <= prog_reset_next;
      first_read_reg <= first_read_next;
    end
  end

  always_comb
  begin
    status_word = inst_status_pkg::ZERO_WORD; // RQ18
    status_word[inst_status_pkg::STAT_REMOTE_BIT] = remote_reg; // RQ9
    status_word[inst_status_pkg::STAT_PROG_RESET_BIT] = prog_reset_reg; // RQ10
  end

  ////////////////////////////////////////////////////////////////////////
  // read decode

  logic rd_valid_reg;
  logic rd_valid_next;
  logic [15:0] rd_data_reg;
  logic [15:0] rd_data_next;
  logic [7:0] blk_off;
  logic [2:0] blk_idx;
  logic [3:0] blk_field;
  logic [2:0] out_idx;
  logic [5:0] out_sel;

  always_comb
  begin
    blk_off = rd_addr - inst_status_pkg::BLK_BASE;
    blk_idx = blk_off[6:4];
    blk_field = blk_off[3:0];
    // fields 4..b are outputs 1..8 of the block
    out_idx = 3'(blk_field - inst_status_pkg::BLK_OUT_FIRST);
    out_sel = {blk_idx, out_idx};
    // every request is answered one cycle later; nothing is refused
    rd_valid_next = rd_en;
    rd_data_next = rd_data_reg;
    if (rd_en)
    begin
      rd_data_next = inst_status_pkg::ZERO_WORD;
      if (rd_addr >= inst_status_pkg::BLK_BASE && blk_off[7] == 1'b0)
      begin
        if (blk_field == inst_status_pkg::BLK_ERROR_CODE)
          rd_data_next = blk_err[blk_idx]; // RQ13
        else if (blk_field == inst_status_pkg::BLK_STATUS)
          rd_data_next = blk_stat[blk_idx]; // RQ15
        else if (blk_field == inst_status_pkg::BLK_SUM)
          rd_data_next = sum_word[blk_idx];
        else if (blk_field == inst_status_pkg::BLK_DIFF)
          rd_data_next = diff_word[blk_idx];
        // fields past the last output read zero
        else if (blk_field <= inst_status_pkg::BLK_OUT_LAST)
          rd_data_next = out_word[out_sel]; // RQ17
      end
      else
      begin
        unique case (rd_addr)
          inst_status_pkg::REG_SPECIAL_MAJOR:
            rd_data_next = special_prog ? special_major : inst_status_pkg::ZERO_WORD; // RQ1
          inst_status_pkg::REG_SPECIAL_MINOR:
            rd_data_next = special_prog ? special_minor : inst_status_pkg::ZERO_WORD; // RQ1
          inst_status_pkg::REG_SERIAL_HI:
            rd_data_next = SERIAL_NUMBER[31:16];
          inst_status_pkg::REG_SERIAL_LO:
            rd_data_next = SERIAL_NUMBER[15:0];
          inst_status_pkg::REG_COMMAND_ERROR:
            rd_data_next = {8'h00, cmd_err_reg}; // RQ3
          inst_status_pkg::REG_INST_STATE:
            rd_data_next = {8'h00, state}; // RQ4 RQ5 RQ6 RQ7
          inst_status_pkg::REG_INST_ERROR:
            rd_data_next = {8'h00, inst_err_reg}; // RQ8
          inst_status_pkg::REG_STATUS_WORD:
            rd_data_next = status_word; // RQ11 RQ12
          default:
            rd_data_next = inst_status_pkg::ZERO_WORD;
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_valid_reg <= 1'b0;
      rd_data_reg <= 16'h0000;
    end
    else
    begin
      rd_valid_reg <= rd_valid_next;
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_valid = rd_valid_reg;
  assign rd_data = rd_data_reg;

endmodule : inst_status_regs
`default_nettype wire
